// ---- ampc_regs.sv ----
// Analog path and mixing control register bank with sample conditioning
//
// How it works
// [R1] Path mode bit0: single-ended stereo or differential mono
// [R2] Mix source: mono aux pin or third line pair
// [R3] Mono record gives (L+R)/2 on both channels
// [R4] Input four: stereo single-ended or differential mono
// [R5] Mic select feeds mic amp instead of input three
// [R6] Six line-out switches, set closes, reset open
// [R7] Third-input line-out switches follow mic select source
// [R8] Line-out bit6: mic/input three mono mixing
// [R9] Line-out bit7: playback converter mono mixing
// [R10] Six headphone switches, set closes, reset open
// [R11] Headphone bit6: mic/input three mono mixing
// [R12] Host holds power-down low at least 150 ns
// [R13] Host keeps power-down low until supplies up
// [R14] Frame and bit clocks undriven until master selected
// [R15] Playback samples are two's complement, zero mid-scale
// [R16] Host sets format and rate before master select
// [R17] Fixed-zero bits ignore writes, read as zero
`timescale 1ns/1ps
`include "ampc_consts.svh"
module ampc_regs
    import ampc_pkg::*;
#(
    parameter int SAMPLE_W = 16
) (
    input  wire logic                I_CLK_SYS,
    input  wire logic                I_RST,
    input  wire logic                I_POWER_DOWN_N,
    input  wire logic [7:0]          I_REG_ADDR,
    input  wire logic [7:0]          I_REG_WDATA,
    input  wire logic                I_REG_WE,
    output logic      [7:0]          O_REG_RDATA,
    input  wire logic                I_MASTER_SEL,
    input  wire logic                I_FRAME_CLOCK_GEN,
    input  wire logic                I_BIT_CLOCK_GEN,
    output logic                     O_FRAME_CLOCK,
    output logic                     O_FRAME_CLOCK_OE,
    output logic                     O_BIT_CLOCK,
    output logic                     O_BIT_CLOCK_OE,
    output logic                     O_LINE_OUT_FORM_SEL,
    output logic                     O_ANALOG_MIX_SOURCE_SEL,
    output logic                     O_REC_MONO_SEL,
    output logic                     O_INPUT4_TYPE_SEL,
    output logic                     O_LEFT_MIC_TO_OUTPUT_SEL,
    output logic                     O_RIGHT_MIC_TO_OUTPUT_SEL,
    output logic      [5:0]          O_LINEOUT_SW,
    output logic      [1:0]          O_LINEOUT_IN3_FROM_MIC,
    output logic                     O_LINEOUT_MIC_MONO_MIX,
    output logic                     O_LINEOUT_DAC_MONO_MIX,
    output logic      [5:0]          O_HEADPHONE_SW,
    output logic      [1:0]          O_HEADPHONE_IN3_FROM_MIC,
    output logic                     O_HEADPHONE_MIC_MONO_MIX,
    input  wire logic [SAMPLE_W-1:0] I_REC_LEFT,
    input  wire logic [SAMPLE_W-1:0] I_REC_RIGHT,
    output logic      [SAMPLE_W-1:0] O_REC_LEFT,
    output logic      [SAMPLE_W-1:0] O_REC_RIGHT,
    input  wire logic [SAMPLE_W-1:0] I_PLAY_SAMPLE,
    output logic      [SAMPLE_W-1:0] O_DAC_CODE
);

    ampc_reg_t           path_mode;
    ampc_reg_t           lineout_mix;
    ampc_reg_t           headphone_mix;
    logic                pdn_meta;
    logic                pdn_sync;
    logic                clock_drive;
    logic [SAMPLE_W-1:0] rec_left;
    logic [SAMPLE_W-1:0] rec_right;
    logic [SAMPLE_W-1:0] dac_code;

    // Address decode and write masking
    wire       hit_mode = (I_REG_ADDR == `AMPC_ADDR_PATH_MODE);
    wire       hit_lo   = (I_REG_ADDR == `AMPC_ADDR_LINEOUT_MIX);
    wire       hit_hp   = (I_REG_ADDR == `AMPC_ADDR_HEADPHONE_MIX);
    wire       pdn_hold = !pdn_sync;
    wire [7:0] wr_mode  = I_REG_WDATA & `AMPC_MASK_PATH_MODE; // R17
    wire [7:0] wr_lo    = I_REG_WDATA & `AMPC_MASK_LINEOUT_MIX;
    wire [7:0] wr_hp    = I_REG_WDATA & `AMPC_MASK_HEADPHONE_MIX; // R17
    wire [7:0] next_rdata = hit_mode ? path_mode :
                            hit_lo   ? lineout_mix :
                            hit_hp   ? headphone_mix : `AMPC_READ_ZERO;

    // Power-down pin is asynchronous to the system clock
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            pdn_meta <= 1'b0;
            pdn_sync <= 1'b0;
        end else begin
            pdn_meta <= I_POWER_DOWN_N;
            pdn_sync <= pdn_meta;
        end
    end

    // Register bank; a low power-down pin clears every field
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            path_mode     <= `AMPC_RESET_VALUE;
            lineout_mix   <= `AMPC_RESET_VALUE;
            headphone_mix <= `AMPC_RESET_VALUE;
        end else if (pdn_hold) begin
            path_mode     <= `AMPC_RESET_VALUE;
            lineout_mix   <= `AMPC_RESET_VALUE;
            headphone_mix <= `AMPC_RESET_VALUE;
        end else if (I_REG_WE) begin
            if (hit_mode) begin
                path_mode <= wr_mode; // R1
            end
            if (hit_lo) begin
                lineout_mix <= wr_lo; // R6
            end
            if (hit_hp) begin
                headphone_mix <= wr_hp; // R10
            end
        end
    end

    // Read data registered so it holds steady for the serial shifter
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            O_REG_RDATA <= `AMPC_READ_ZERO;
        end else begin
            O_REG_RDATA <= next_rdata; // R17
        end
    end

    // Path mode fields straight to the analog switches
    assign O_LINE_OUT_FORM_SEL       = path_mode[`AMPC_BIT_LINE_OUT_FORM]; // R1
    assign O_ANALOG_MIX_SOURCE_SEL   = path_mode[`AMPC_BIT_MIX_SOURCE]; // R2
    assign O_REC_MONO_SEL            = path_mode[`AMPC_BIT_REC_MONO]; // R3
    assign O_INPUT4_TYPE_SEL         = path_mode[`AMPC_BIT_INPUT4_TYPE]; // R4
    assign O_LEFT_MIC_TO_OUTPUT_SEL  = path_mode[`AMPC_BIT_LEFT_MIC_SEL]; // R5
    assign O_RIGHT_MIC_TO_OUTPUT_SEL = path_mode[`AMPC_BIT_RIGHT_MIC_SEL]; // R5

    // Mixing switches; third-input pair takes the mic source when selected
    assign O_LINEOUT_SW = lineout_mix[`AMPC_SW_MSB:0]; // R6
    assign O_LINEOUT_IN3_FROM_MIC = {O_RIGHT_MIC_TO_OUTPUT_SEL,
                                     O_LEFT_MIC_TO_OUTPUT_SEL}; // R7
    assign O_LINEOUT_MIC_MONO_MIX = lineout_mix[`AMPC_BIT_MIC_MONO]; // R8
    assign O_LINEOUT_DAC_MONO_MIX = lineout_mix[`AMPC_BIT_DAC_MONO]; // R9
    assign O_HEADPHONE_SW = headphone_mix[`AMPC_SW_MSB:0]; // R10
    assign O_HEADPHONE_IN3_FROM_MIC = O_LINEOUT_IN3_FROM_MIC; // R7
    assign O_HEADPHONE_MIC_MONO_MIX = headphone_mix[`AMPC_BIT_MIC_MONO]; // R11

    // Mono record average; one extra bit keeps the sum from wrapping
    wire signed [SAMPLE_W:0] rec_sum = $signed({I_REC_LEFT[SAMPLE_W-1],
                                                I_REC_LEFT})
                                     + $signed({I_REC_RIGHT[SAMPLE_W-1],
                                                I_REC_RIGHT});
    wire [SAMPLE_W-1:0] rec_avg = rec_sum[SAMPLE_W:1]; // R3
    wire [SAMPLE_W-1:0] next_rec_left  = O_REC_MONO_SEL ? rec_avg
                                                        : I_REC_LEFT;
    wire [SAMPLE_W-1:0] next_rec_right = O_REC_MONO_SEL ? rec_avg
                                                        : I_REC_RIGHT;
    // Two's complement to offset code: flipping the sign puts 0 at mid
    wire [SAMPLE_W-1:0] next_dac_code =
        {~I_PLAY_SAMPLE[SAMPLE_W-1], I_PLAY_SAMPLE[SAMPLE_W-2:0]}; // R15

    // Sample pipeline, one stage
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            rec_left  <= '0;
            rec_right <= '0;
            dac_code  <= '0;
        end else begin
            rec_left  <= next_rec_left; // R3
            rec_right <= next_rec_right; // R3
            dac_code  <= next_dac_code; // R15
        end
    end
    assign O_REC_LEFT  = rec_left;
    assign O_REC_RIGHT = rec_right;
    assign O_DAC_CODE  = dac_code;

    // Clock pins stay released until master select; pull-ups hold them
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            clock_drive <= 1'b0;
        end else begin
            clock_drive <= I_MASTER_SEL && pdn_sync; // R14 R16
        end
    end
    assign O_FRAME_CLOCK_OE = clock_drive; // R14
    assign O_BIT_CLOCK_OE   = clock_drive; // R14
    assign O_FRAME_CLOCK    = clock_drive & I_FRAME_CLOCK_GEN;
    assign O_BIT_CLOCK      = clock_drive & I_BIT_CLOCK_GEN;

    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);

    sequence s_write_mode;
        I_REG_WE && hit_mode && pdn_sync;
    endsequence
    sequence s_write_hp;
        I_REG_WE && hit_hp && pdn_sync;
    endsequence

    a_mode_write_lands: assert property ( // R1
        s_write_mode |=> path_mode == $past(wr_mode))
        else $error("path mode write not stored");
    a_mode_zero_bits: assert property ( // R17
        path_mode[7:6] == 2'b00 && headphone_mix[7] == 1'b0)
        else $error("fixed zero bit set");
    a_lineout_write: assert property ( // R6
        I_REG_WE && hit_lo && pdn_sync |=>
            O_LINEOUT_SW == $past(I_REG_WDATA[5:0])
            && O_LINEOUT_DAC_MONO_MIX == $past(I_REG_WDATA[7]))
        else $error("line-out switches not updated");
    a_hp_write_mono: assert property ( // R11
        s_write_hp |=> O_HEADPHONE_MIC_MONO_MIX == $past(I_REG_WDATA[6]))
        else $error("headphone mono bit wrong");
    a_pdn_clears_bank: assert property ( // R10
        !pdn_sync |=> path_mode == 8'h00 && lineout_mix == 8'h00
            && headphone_mix == 8'h00)
        else $error("power-down did not clear bank");
    a_clock_release: assert property ( // R14
        !I_MASTER_SEL |=> !O_FRAME_CLOCK_OE && !O_BIT_CLOCK_OE)
        else $error("clock pins driven without master select");
    a_rec_mono_avg: assert property ( // R3
        O_REC_MONO_SEL |=> O_REC_LEFT == O_REC_RIGHT)
        else $error("mono record channels differ");
    a_rec_stereo_pass: assert property ( // R3
        !O_REC_MONO_SEL |=> O_REC_LEFT == $past(I_REC_LEFT))
        else $error("stereo record altered sample");
    a_dac_mid_scale: assert property ( // R15
        I_PLAY_SAMPLE == 16'h0000 |=> O_DAC_CODE == 16'h8000)
        else $error("zero sample not mid-scale");
    a_read_unmapped: assert property ( // R17
        !(hit_mode || hit_lo || hit_hp) |=> O_REG_RDATA == 8'h00)
        else $error("unmapped read not zero");

endmodule

// ---- ampc_consts.svh ----
// Offsets, field positions, masks and reset values of the analog path bank
`ifndef AMPC_CONSTS_SVH
`define AMPC_CONSTS_SVH

`define AMPC_ADDR_PATH_MODE     8'h21
`define AMPC_ADDR_LINEOUT_MIX   8'h22
`define AMPC_ADDR_HEADPHONE_MIX 8'h23

`define AMPC_RESET_VALUE        8'h00
`define AMPC_READ_ZERO          8'h00

// Writable bits; fixed-zero positions are cleared by these masks
`define AMPC_MASK_PATH_MODE     8'h3f
`define AMPC_MASK_LINEOUT_MIX   8'hff
`define AMPC_MASK_HEADPHONE_MIX 8'h7f

// Path mode fields
`define AMPC_BIT_LINE_OUT_FORM  0
`define AMPC_BIT_MIX_SOURCE     1
`define AMPC_BIT_REC_MONO       2
`define AMPC_BIT_INPUT4_TYPE    3
`define AMPC_BIT_LEFT_MIC_SEL   4
`define AMPC_BIT_RIGHT_MIC_SEL  5

// Mixing select fields: switches in bits 5..0, mono options above
`define AMPC_SW_MSB             5
`define AMPC_BIT_MIC_MONO       6
`define AMPC_BIT_DAC_MONO       7

// Playback sample sign bit
`define AMPC_SAMPLE_MSB         15

`endif

// ---- ampc_pkg.sv ----
// Types shared by the analog path control bank
package ampc_pkg;
    typedef logic [7:0]  ampc_reg_t;
    typedef logic [5:0]  ampc_switch_t;
    typedef logic [15:0] ampc_sample_t;
endpackage

// ---- ampc_host_model.sv ----
// Host model driving the power-down pin of the bank
`timescale 1ns/1ps
module ampc_host_model #(
    parameter int LOW_CYCLES = 38
) (
    input  wire logic i_clk,
    input  wire logic i_supplies_up,
    input  wire logic i_reset_req,
    output logic      o_power_down_n
);
    int cnt = 0;
    // Low pulse of 38 cycles, 152 ns, so no pulse falls short
    // Counts on the rising edge so the bench's falling-edge drive never races
    always @(posedge i_clk) begin
        if (!i_supplies_up || i_reset_req) begin
            cnt <= LOW_CYCLES;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
    // Pin stays low until supplies are up
    assign o_power_down_n = i_supplies_up && (cnt == 0);
endmodule

// ---- ampc_regs_tb_top.sv ----
// Self-checking bench for the analog path control bank
`timescale 1ns/1ps
module ampc_regs_tb_top;
    import ampc_pkg::*;
    logic         clk, rst, sup, pdq, power_down_n, we, msel, fgen, bgen;
    logic         lof, msrc, recm, in4, lmic, rmic, lodm, lomm, hpmm;
    logic         foe, boe, fclk, bclk;
    logic [1:0]   lo3, hp3;
    ampc_reg_t    addr, wdata, rdata;
    ampc_switch_t losw, hpsw;
    ampc_sample_t rl, rr, orl, orr, play, dac;
    ampc_sample_t pv[3] = '{16'h7fff, 16'h8000, 16'h0000};
    ampc_sample_t pe[3] = '{16'hffff, 16'h0000, 16'h8000};
    ampc_reg_t    ra[3] = '{8'h21, 8'h22, 8'h23};
    ampc_reg_t    rm[3] = '{8'h3f, 8'hff, 8'h7f};
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;

    ampc_host_model HOST (.i_clk(clk), .i_supplies_up(sup),
        .i_reset_req(pdq), .o_power_down_n(power_down_n));

    ampc_regs DUT (.I_CLK_SYS(clk), .I_RST(rst), .I_POWER_DOWN_N(power_down_n),
        .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_REG_WE(we),
        .O_REG_RDATA(rdata), .I_MASTER_SEL(msel),
        .I_FRAME_CLOCK_GEN(fgen), .I_BIT_CLOCK_GEN(bgen),
        .O_FRAME_CLOCK(fclk), .O_FRAME_CLOCK_OE(foe), .O_BIT_CLOCK(bclk),
        .O_BIT_CLOCK_OE(boe), .O_LINE_OUT_FORM_SEL(lof),
        .O_ANALOG_MIX_SOURCE_SEL(msrc), .O_REC_MONO_SEL(recm),
        .O_INPUT4_TYPE_SEL(in4), .O_LEFT_MIC_TO_OUTPUT_SEL(lmic),
        .O_RIGHT_MIC_TO_OUTPUT_SEL(rmic), .O_LINEOUT_SW(losw),
        .O_LINEOUT_IN3_FROM_MIC(lo3), .O_LINEOUT_MIC_MONO_MIX(lomm),
        .O_LINEOUT_DAC_MONO_MIX(lodm), .O_HEADPHONE_SW(hpsw),
        .O_HEADPHONE_IN3_FROM_MIC(hp3), .O_HEADPHONE_MIC_MONO_MIX(hpmm),
        .I_REC_LEFT(rl), .I_REC_RIGHT(rr), .O_REC_LEFT(orl),
        .O_REC_RIGHT(orr), .I_PLAY_SAMPLE(play), .O_DAC_CODE(dac));

    // Free-running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One write strobe, then a cycle gap
    task automatic wr(input ampc_reg_t a, input ampc_reg_t d);
        @(negedge clk);
        addr = a;
        wdata = d;
        we = 1'b1;
        @(negedge clk);
        we = 1'b0;
    endtask

    // Read data is registered, so sample one cycle after the address
    task automatic rd(input ampc_reg_t a, input ampc_reg_t exp);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        chk(16'(rdata), 16'(exp));
    endtask

    task automatic complete_run();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            complete_run();
        end
    end

    // Main sequence; inputs move on the falling edge only
    initial begin
        {rst, sup, pdq, we, msel, fgen, bgen, addr, wdata} = '0;
        {rl, rr, play} = '0;
        rst = 1'b1;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        sup = 1'b1;
        repeat (44) @(negedge clk);
        for (int i = 0; i < 3; i++) begin
            rd(ra[i], 8'h00);
            wr(ra[i], 8'hff);
            rd(ra[i], rm[i]);
        end
        wr(8'h24, 8'hff);
        rd(8'h24, 8'h00);
        // Walk one bit so swapped positions show up
        for (int b = 0; b < 8; b++) begin
            wr(8'h22, 8'(1 << b));
            chk(16'({lodm, lomm, losw}), 16'(1 << b));
            wr(8'h23, 8'(1 << b));
            chk(16'({hpmm, hpsw}), 16'(1 << b) & 16'h7f);
            wr(8'h21, 8'(1 << b));
            chk(16'({rmic, lmic, in4, recm, msrc, lof}),
                16'(1 << b) & 16'h3f);
            chk(16'({lo3, hp3}), 16'({b == 5, b == 4, b == 5, b == 4}));
        end
        wr(8'h21, 8'h04);
        @(negedge clk);
        rl = 16'h0004;
        rr = 16'hffff;
        @(negedge clk);
        chk(orl, 16'h0001);
        chk(orr, 16'h0001);
        wr(8'h21, 8'h00);
        // Write edge still saw mono select; stereo shows one cycle later
        @(negedge clk);
        chk(orl, 16'h0004);
        chk(orr, 16'hffff);
        for (int i = 0; i < 3; i++) begin
            play = pv[i];
            @(negedge clk);
            chk(dac, pe[i]);
        end
        fgen = 1'b1;
        bgen = 1'b1;
        @(negedge clk);
        chk(16'({foe, boe, fclk, bclk}), 16'h0);
        // Format fields are already written before master select
        msel = 1'b1;
        @(negedge clk);
        chk(16'({foe, boe, fclk, bclk}), 16'hf);
        bgen = 1'b0;
        @(negedge clk);
        chk(16'({fclk, bclk}), 16'h2);
        wr(8'h22, 8'ha5);
        pdq = 1'b1;
        @(negedge clk);
        pdq = 1'b0;
        repeat (4) @(negedge clk);
        chk(16'({losw, foe}), 16'h0);
        wr(8'h22, 8'hff);
        rd(8'h22, 8'h00);
        repeat (44) @(negedge clk);
        wr(8'h22, 8'h5a);
        rd(8'h22, 8'h5a);
        complete_run();
    end
endmodule
